// ===== design/ppp_buffer.sv
module ppp_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_q;
  logic [PW-1:0] rd_q;
  logic [PW:0] cnt_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  wire [PW-1:0] wr_nx = (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
  wire [PW-1:0] rd_nx = (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
  assign in_ready = (cnt_q != (PW + 1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else if (ce) begin
      if (push) wr_q <= wr_nx;
      if (pop) rd_q <= rd_nx;
      cnt_q <= cnt_q + (PW + 1)'(push) - (PW + 1)'(pop);
    end
  end
  always_ff @(posedge clk) begin
    if (ce && push) mem_q[wr_q] <= in_data;
  end
endmodule

// ===== design/ppp_host_decode.sv
module ppp_host_decode (
  input wire logic serial_one_select,
  input wire logic serial_two_select,
  input wire logic printer_port_select_n,
  input wire logic host_read_strobe_n,
  input wire logic host_write_strobe_n,
  output logic prn_sel,
  output logic prn_rd,
  output logic prn_wr,
  output logic any_rd
);
  // exactly one unit may be selected; otherwise nothing responds
  wire s1 = serial_one_select;
  wire s2 = serial_two_select;
  wire sp = !printer_port_select_n;
  wire one_hot = (32'(s1) + 32'(s2) + 32'(sp)) == 32'd1;
  assign prn_sel = sp && one_hot;
  assign prn_rd = prn_sel && !host_read_strobe_n;
  assign prn_wr = prn_sel && !host_write_strobe_n;
  assign any_rd = one_hot && !host_read_strobe_n;
endmodule

// ===== design/ppp_pkg.sv
package ppp_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 3;
  // printer port register indices
  localparam logic [2:0] REG_DATA = 3'h0;
  localparam logic [2:0] REG_STATUS = 3'h1;
  localparam logic [2:0] REG_CONTROL = 3'h2;
  // status field positions
  localparam int ST_BUSY = 7;
  localparam int ST_ACK = 6;
  localparam int ST_PAPER = 5;
  localparam int ST_SEL = 4;
  localparam int ST_ERR = 3;
  localparam int ST_IRQ = 2;
  // control field positions
  localparam int CT_STROBE = 0;
  localparam int CT_FEED = 1;
  localparam int CT_INIT = 2;
  localparam int CT_SELOUT = 3;
  localparam int CT_DIR_IN = 5;
  localparam logic [7:0] CONTROL_RESET = 8'h04;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam int BUF_DEPTH = 2;
endpackage

// ===== design/ppp_top.sv
module ppp_top (
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic CE,
  input wire logic SERIAL_ONE_SELECT,
  input wire logic SERIAL_TWO_SELECT,
  input wire logic PRINTER_PORT_SELECT_N,
  input wire logic HOST_READ_STROBE_N,
  input wire logic HOST_WRITE_STROBE_N,
  input wire logic [2:0] HOST_ADDR,
  input wire logic [7:0] HOST_DATA_BUS_IN,
  output logic [7:0] HOST_DATA_BUS_OUT,
  output logic HOST_DATA_BUS_OE,
  output logic BUS_BUFFER_DRIVE_OUT,
  input wire logic PRINTER_OUTPUT_ENABLE_N,
  input wire logic [7:0] PRINTER_DATA_LINES_IN,
  output logic [7:0] PRINTER_DATA_LINES_OUT,
  output logic PRINTER_DATA_LINES_OE,
  input wire logic PRINTER_LATCH_STROBE_N_IN,
  output logic PRINTER_LATCH_STROBE_N_OUT,
  output logic PRINTER_LATCH_STROBE_N_OE,
  input wire logic PAPER_AUTOFEED_N_IN,
  output logic PAPER_AUTOFEED_N_OUT,
  output logic PAPER_AUTOFEED_N_OE,
  input wire logic PRINTER_INIT_N_IN,
  output logic PRINTER_INIT_N_OUT,
  output logic PRINTER_INIT_N_OE,
  input wire logic PRINTER_SELECT_OUT_N_IN,
  output logic PRINTER_SELECT_OUT_N_OUT,
  output logic PRINTER_SELECT_OUT_N_OE,
  output logic PRINTER_IRQ,
  input wire logic PRINTER_ERROR_N_IN,
  input wire logic PRINTER_SELECTED_IN,
  input wire logic PRINTER_BUSY_IN,
  input wire logic PAPER_OUT_IN,
  input wire logic PRINTER_ACK_N_IN,
  input wire logic BUF_OUT_READY,
  output logic BUF_IN_READY
);
  logic prn_sel;
  logic prn_rd;
  logic prn_wr;
  logic any_rd;
  logic [7:0] control_q;
  logic [7:0] rd_q;
  logic rd_oe_q;
  logic wr_prev_q;
  logic irq_q;
  logic [7:0] buf_out;
  logic buf_valid;
  logic buf_in_ready;

  ppp_host_decode u_dec (
    .serial_one_select(SERIAL_ONE_SELECT),
    .serial_two_select(SERIAL_TWO_SELECT),
    .printer_port_select_n(PRINTER_PORT_SELECT_N),
    .host_read_strobe_n(HOST_READ_STROBE_N),
    .host_write_strobe_n(HOST_WRITE_STROBE_N),
    .prn_sel(prn_sel),
    .prn_rd(prn_rd),
    .prn_wr(prn_wr),
    .any_rd(any_rd)
  );

  // one write per strobe: capture on its first sampled cycle
  wire wr_edge = prn_wr && !wr_prev_q;
  wire wr_data = wr_edge && (HOST_ADDR == ppp_pkg::REG_DATA);
  wire wr_ctrl = wr_edge && (HOST_ADDR == ppp_pkg::REG_CONTROL);

  ppp_buffer #(
    .WIDTH(ppp_pkg::DATA_W),
    .DEPTH(ppp_pkg::BUF_DEPTH)
  ) u_buf (
    .clk(CLOCK),
    .rst(RESET),
    .ce(CE),
    .in_valid(wr_data),
    .in_ready(buf_in_ready),
    .in_data(HOST_DATA_BUS_IN),
    .out_valid(buf_valid),
    .out_ready(BUF_OUT_READY),
    .out_data(buf_out)
  );
  assign BUF_IN_READY = buf_in_ready;

  // pin drive gating
  wire pins_on = !PRINTER_OUTPUT_ENABLE_N;
  wire data_drive = pins_on && prn_sel && !control_q[ppp_pkg::CT_DIR_IN];

  // irq: error low or paper out
  wire irq_cause = !PRINTER_ERROR_N_IN || PAPER_OUT_IN;

  wire [7:0] status_word = {
    PRINTER_BUSY_IN,
    PRINTER_ACK_N_IN,
    PAPER_OUT_IN,
    PRINTER_SELECTED_IN,
    PRINTER_ERROR_N_IN,
    irq_q,
    2'h0
  };
  wire [7:0] data_view = control_q[ppp_pkg::CT_DIR_IN] ? PRINTER_DATA_LINES_IN : buf_out;
  wire [7:0] rd_mux = (HOST_ADDR == ppp_pkg::REG_DATA) ? data_view :
                      (HOST_ADDR == ppp_pkg::REG_STATUS) ? status_word :
                      (HOST_ADDR == ppp_pkg::REG_CONTROL) ? control_q : 8'h00;

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      control_q <= ppp_pkg::CONTROL_RESET;
      wr_prev_q <= 1'b0;
    end else if (CE) begin
      wr_prev_q <= prn_wr;
      if (wr_ctrl) control_q <= HOST_DATA_BUS_IN;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      irq_q <= 1'b0;
    end else if (CE) begin
      irq_q <= irq_cause;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      rd_q <= 8'h00;
      rd_oe_q <= 1'b0;
    end else if (CE) begin
      rd_q <= prn_rd ? rd_mux : 8'h00;
      rd_oe_q <= prn_rd;
    end
  end

  assign HOST_DATA_BUS_OUT = rd_q;
  assign HOST_DATA_BUS_OE = rd_oe_q && prn_rd;
  assign BUS_BUFFER_DRIVE_OUT = any_rd;
  assign PRINTER_IRQ = irq_q;

  assign PRINTER_DATA_LINES_OUT = buf_out;
  assign PRINTER_DATA_LINES_OE = data_drive;
  // active-low controls: bit set means line pulled low, except init, where a clear bit pulls the line low
  assign PRINTER_LATCH_STROBE_N_OUT = !control_q[ppp_pkg::CT_STROBE];
  assign PAPER_AUTOFEED_N_OUT = !control_q[ppp_pkg::CT_FEED];
  assign PRINTER_INIT_N_OUT = control_q[ppp_pkg::CT_INIT];
  assign PRINTER_SELECT_OUT_N_OUT = !control_q[ppp_pkg::CT_SELOUT];
  assign PRINTER_LATCH_STROBE_N_OE = pins_on;
  assign PAPER_AUTOFEED_N_OE = pins_on;
  assign PRINTER_INIT_N_OE = pins_on;
  assign PRINTER_SELECT_OUT_N_OE = pins_on;

  a_irq_follows: assert property (@(posedge CLOCK) disable iff (RESET)
    CE && !PRINTER_ERROR_N_IN |=> PRINTER_IRQ)
    else $error("irq not raised on error");
  a_irq_paper: assert property (@(posedge CLOCK) disable iff (RESET)
    CE && PAPER_OUT_IN |=> PRINTER_IRQ)
    else $error("irq not raised on paper out");
  a_irq_reset: assert property (@(posedge CLOCK)
    RESET |=> !PRINTER_IRQ)
    else $error("irq not cleared by reset");
  a_pins_float: assert property (@(posedge CLOCK) disable iff (RESET)
    PRINTER_OUTPUT_ENABLE_N |-> !PRINTER_DATA_LINES_OE && !PRINTER_LATCH_STROBE_N_OE)
    else $error("printer pins driven while disabled");
  a_data_desel: assert property (@(posedge CLOCK) disable iff (RESET)
    PRINTER_PORT_SELECT_N |-> !PRINTER_DATA_LINES_OE)
    else $error("data lines driven while deselected");
  a_bus_idle: assert property (@(posedge CLOCK) disable iff (RESET)
    HOST_READ_STROBE_N |-> !HOST_DATA_BUS_OE)
    else $error("host bus driven without read");
  a_buffer_read: assert property (@(posedge CLOCK) disable iff (RESET)
    HOST_DATA_BUS_OE |-> BUS_BUFFER_DRIVE_OUT)
    else $error("bus buffer not steered on read");
  a_one_select: assert property (@(posedge CLOCK) disable iff (RESET)
    (SERIAL_ONE_SELECT && !PRINTER_PORT_SELECT_N) |-> !HOST_DATA_BUS_OE)
    else $error("responded with two selects");
  a_ctrl_write: assert property (@(posedge CLOCK) disable iff (RESET)
    CE && wr_ctrl |=> control_q == $past(HOST_DATA_BUS_IN))
    else $error("control write lost");

  a_irq_clear: assert property (@(posedge CLOCK) disable iff (RESET)
    CE && PRINTER_ERROR_N_IN && !PAPER_OUT_IN |=> !PRINTER_IRQ)
    else $error("irq held without cause");
  a_irq_status: assert property (@(posedge CLOCK) disable iff (RESET)
    CE && prn_rd && HOST_ADDR == ppp_pkg::REG_STATUS |=>
      HOST_DATA_BUS_OUT[ppp_pkg::ST_IRQ] == $past(PRINTER_IRQ))
    else $error("irq level not shown in status");
  a_pins_drive: assert property (@(posedge CLOCK) disable iff (RESET)
    !PRINTER_OUTPUT_ENABLE_N |-> PRINTER_LATCH_STROBE_N_OE && PAPER_AUTOFEED_N_OE &&
      PRINTER_INIT_N_OE && PRINTER_SELECT_OUT_N_OE)
    else $error("printer pins not driven while enabled");
  a_ctl_float: assert property (@(posedge CLOCK) disable iff (RESET)
    PRINTER_OUTPUT_ENABLE_N |-> !PAPER_AUTOFEED_N_OE && !PRINTER_INIT_N_OE &&
      !PRINTER_SELECT_OUT_N_OE)
    else $error("control pins driven while disabled");
  a_data_dir: assert property (@(posedge CLOCK) disable iff (RESET)
    control_q[ppp_pkg::CT_DIR_IN] |-> !PRINTER_DATA_LINES_OE)
    else $error("data lines driven in input direction");
  a_data_drive: assert property (@(posedge CLOCK) disable iff (RESET)
    !PRINTER_OUTPUT_ENABLE_N && prn_sel && !control_q[ppp_pkg::CT_DIR_IN] |->
      PRINTER_DATA_LINES_OE)
    else $error("data lines not driven while selected");
  a_head_ready: assert property (@(posedge CLOCK) disable iff (RESET)
    !buf_valid |-> BUF_IN_READY)
    else $error("empty buffer refuses a byte");

  a_strobe_low: assert property (@(posedge CLOCK) disable iff (RESET)
    CE && wr_ctrl && HOST_DATA_BUS_IN[ppp_pkg::CT_STROBE] |=> !PRINTER_LATCH_STROBE_N_OUT)
    else $error("strobe not pulled low");
  a_strobe_high: assert property (@(posedge CLOCK) disable iff (RESET)
    CE && wr_ctrl && !HOST_DATA_BUS_IN[ppp_pkg::CT_STROBE] |=> PRINTER_LATCH_STROBE_N_OUT)
    else $error("strobe not released");
  a_feed_low: assert property (@(posedge CLOCK) disable iff (RESET)
    CE && wr_ctrl && HOST_DATA_BUS_IN[ppp_pkg::CT_FEED] |=> !PAPER_AUTOFEED_N_OUT)
    else $error("autofeed not pulled low");
  a_feed_high: assert property (@(posedge CLOCK) disable iff (RESET)
    CE && wr_ctrl && !HOST_DATA_BUS_IN[ppp_pkg::CT_FEED] |=> PAPER_AUTOFEED_N_OUT)
    else $error("autofeed not released");
  a_select_low: assert property (@(posedge CLOCK) disable iff (RESET)
    CE && wr_ctrl && HOST_DATA_BUS_IN[ppp_pkg::CT_SELOUT] |=> !PRINTER_SELECT_OUT_N_OUT)
    else $error("printer select not pulled low");
  a_select_high: assert property (@(posedge CLOCK) disable iff (RESET)
    CE && wr_ctrl && !HOST_DATA_BUS_IN[ppp_pkg::CT_SELOUT] |=> PRINTER_SELECT_OUT_N_OUT)
    else $error("printer select not released");
  a_init_low: assert property (@(posedge CLOCK) disable iff (RESET)
    CE && wr_ctrl && !HOST_DATA_BUS_IN[ppp_pkg::CT_INIT] |=> !PRINTER_INIT_N_OUT)
    else $error("init not pulled low");
  a_init_high: assert property (@(posedge CLOCK) disable iff (RESET)
    CE && wr_ctrl && HOST_DATA_BUS_IN[ppp_pkg::CT_INIT] |=> PRINTER_INIT_N_OUT)
    else $error("init not released");
  a_strobe_reset: assert property (@(posedge CLOCK)
    RESET |=> PRINTER_LATCH_STROBE_N_OUT)
    else $error("strobe active after reset");
  a_init_reset: assert property (@(posedge CLOCK)
    RESET |=> PRINTER_INIT_N_OUT)
    else $error("init active after reset");

  a_ctrl_hold: assert property (@(posedge CLOCK) disable iff (RESET)
    !(CE && wr_ctrl) |=> $stable(control_q))
    else $error("control changed without write");
  a_wr_refused: assert property (@(posedge CLOCK) disable iff (RESET)
    SERIAL_ONE_SELECT || SERIAL_TWO_SELECT |=> $stable(control_q))
    else $error("printer took write meant for serial unit");
  a_rd_drive: assert property (@(posedge CLOCK) disable iff (RESET)
    CE && prn_rd ##1 prn_rd |-> HOST_DATA_BUS_OE)
    else $error("host bus not driven on read");
  a_ctrl_read: assert property (@(posedge CLOCK) disable iff (RESET)
    CE && prn_rd && HOST_ADDR == ppp_pkg::REG_CONTROL |=>
      HOST_DATA_BUS_OUT == $past(control_q))
    else $error("control read wrong");
  a_addr_unmapped: assert property (@(posedge CLOCK) disable iff (RESET)
    CE && prn_rd && HOST_ADDR > ppp_pkg::REG_CONTROL |=> HOST_DATA_BUS_OUT == 8'h00)
    else $error("unmapped read not zero");
  a_data_read: assert property (@(posedge CLOCK) disable iff (RESET)
    CE && prn_rd && HOST_ADDR == ppp_pkg::REG_DATA && control_q[ppp_pkg::CT_DIR_IN] |=>
      HOST_DATA_BUS_OUT == $past(PRINTER_DATA_LINES_IN))
    else $error("input data read wrong");
  a_buffer_printer: assert property (@(posedge CLOCK) disable iff (RESET)
    !HOST_READ_STROBE_N && !PRINTER_PORT_SELECT_N && !SERIAL_ONE_SELECT &&
      !SERIAL_TWO_SELECT |-> BUS_BUFFER_DRIVE_OUT)
    else $error("bus buffer idle on printer read");
  a_buffer_serial: assert property (@(posedge CLOCK) disable iff (RESET)
    !HOST_READ_STROBE_N && SERIAL_TWO_SELECT && !SERIAL_ONE_SELECT &&
      PRINTER_PORT_SELECT_N |-> BUS_BUFFER_DRIVE_OUT)
    else $error("bus buffer idle on serial read");
  a_buffer_idle: assert property (@(posedge CLOCK) disable iff (RESET)
    HOST_READ_STROBE_N |-> !BUS_BUFFER_DRIVE_OUT)
    else $error("bus buffer steered without read");

  a_status_busy: assert property (@(posedge CLOCK) disable iff (RESET)
    CE && prn_rd && HOST_ADDR == ppp_pkg::REG_STATUS |=>
      HOST_DATA_BUS_OUT[ppp_pkg::ST_BUSY] == $past(PRINTER_BUSY_IN))
    else $error("busy level not shown in status");
  a_status_ack: assert property (@(posedge CLOCK) disable iff (RESET)
    CE && prn_rd && HOST_ADDR == ppp_pkg::REG_STATUS |=>
      HOST_DATA_BUS_OUT[ppp_pkg::ST_ACK] == $past(PRINTER_ACK_N_IN))
    else $error("ack level not shown in status");
  a_status_paper: assert property (@(posedge CLOCK) disable iff (RESET)
    CE && prn_rd && HOST_ADDR == ppp_pkg::REG_STATUS |=>
      HOST_DATA_BUS_OUT[ppp_pkg::ST_PAPER] == $past(PAPER_OUT_IN))
    else $error("paper level not shown in status");
  a_status_select: assert property (@(posedge CLOCK) disable iff (RESET)
    CE && prn_rd && HOST_ADDR == ppp_pkg::REG_STATUS |=>
      HOST_DATA_BUS_OUT[ppp_pkg::ST_SEL] == $past(PRINTER_SELECTED_IN))
    else $error("selected level not shown in status");
  a_status_error: assert property (@(posedge CLOCK) disable iff (RESET)
    CE && prn_rd && HOST_ADDR == ppp_pkg::REG_STATUS |=>
      HOST_DATA_BUS_OUT[ppp_pkg::ST_ERR] == $past(PRINTER_ERROR_N_IN))
    else $error("error level not shown in status");
endmodule

// ===== tb/ppp_printer_model.sv
module ppp_printer_model (
  input wire logic clk,
  input wire logic err_now,
  input wire logic paper_now,
  input wire logic busy_now,
  input wire logic sel_out_n,
  output logic error_n,
  output logic selected,
  output logic busy,
  output logic paper_out,
  output logic ack_n,
  output logic pop
);
  timeunit 1ns;
  timeprecision 1ps;
  assign error_n = !err_now;
  assign paper_out = paper_now;
  assign selected = !sel_out_n;
  assign busy = busy_now;
  // takes a byte only while idle
  assign pop = !busy_now;
  always_ff @(posedge clk) begin
    ack_n <= !pop;
  end
endmodule

// ===== tb/tb_parallel_printer_port.sv
module tb_parallel_printer_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLOCK, RESET, CE, SERIAL_ONE_SELECT, SERIAL_TWO_SELECT, PRINTER_PORT_SELECT_N;
  logic HOST_READ_STROBE_N, HOST_WRITE_STROBE_N, HOST_DATA_BUS_OE, BUS_BUFFER_DRIVE_OUT;
  logic [2:0] HOST_ADDR;
  logic [7:0] HOST_DATA_BUS_IN, HOST_DATA_BUS_OUT, PRINTER_DATA_LINES_IN, PRINTER_DATA_LINES_OUT;
  logic PRINTER_OUTPUT_ENABLE_N, PRINTER_DATA_LINES_OE, PRINTER_IRQ, BUF_OUT_READY, BUF_IN_READY;
  logic PRINTER_LATCH_STROBE_N_IN, PRINTER_LATCH_STROBE_N_OUT, PRINTER_LATCH_STROBE_N_OE;
  logic PAPER_AUTOFEED_N_IN, PAPER_AUTOFEED_N_OUT, PAPER_AUTOFEED_N_OE;
  logic PRINTER_INIT_N_IN, PRINTER_INIT_N_OUT, PRINTER_INIT_N_OE;
  logic PRINTER_SELECT_OUT_N_IN, PRINTER_SELECT_OUT_N_OUT, PRINTER_SELECT_OUT_N_OE;
  logic PRINTER_ERROR_N_IN, PRINTER_SELECTED_IN, PRINTER_BUSY_IN, PAPER_OUT_IN, PRINTER_ACK_N_IN;
  logic err_now, paper_now, busy_now;
  int err_count = 0;
  int tests_run = 0;
  // wire levels: pull-ups on control lines, far side drives data when released
  assign PRINTER_DATA_LINES_IN = PRINTER_DATA_LINES_OE ? PRINTER_DATA_LINES_OUT : 8'h3C;
  assign PRINTER_LATCH_STROBE_N_IN = PRINTER_LATCH_STROBE_N_OE ? PRINTER_LATCH_STROBE_N_OUT : 1'b1;
  assign PAPER_AUTOFEED_N_IN = PAPER_AUTOFEED_N_OE ? PAPER_AUTOFEED_N_OUT : 1'b1;
  assign PRINTER_INIT_N_IN = PRINTER_INIT_N_OE ? PRINTER_INIT_N_OUT : 1'b1;
  assign PRINTER_SELECT_OUT_N_IN = PRINTER_SELECT_OUT_N_OE ? PRINTER_SELECT_OUT_N_OUT : 1'b1;
  ppp_top i_dut (.*);
  ppp_printer_model i_prn (.clk(CLOCK), .err_now(err_now), .paper_now(paper_now),
    .busy_now(busy_now), .sel_out_n(PRINTER_SELECT_OUT_N_IN), .error_n(PRINTER_ERROR_N_IN),
    .selected(PRINTER_SELECTED_IN), .busy(PRINTER_BUSY_IN), .paper_out(PAPER_OUT_IN),
    .ack_n(PRINTER_ACK_N_IN), .pop(BUF_OUT_READY));
  always #2.5 CLOCK = !CLOCK;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks=%0d mismatches=%0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    PRINTER_PORT_SELECT_N = 1'b0;
    HOST_ADDR = a;
    HOST_DATA_BUS_IN = d;
    HOST_WRITE_STROBE_N = 1'b0;
    @(negedge CLOCK);
    HOST_WRITE_STROBE_N = 1'b1;
    PRINTER_PORT_SELECT_N = 1'b1;
    @(negedge CLOCK);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] exp, input logic resp);
    PRINTER_PORT_SELECT_N = 1'b0;
    HOST_ADDR = a;
    HOST_READ_STROBE_N = 1'b0;
    @(negedge CLOCK);
    chk({6'h00, HOST_DATA_BUS_OE, BUS_BUFFER_DRIVE_OUT}, {6'h00, resp, resp});
    if (resp) chk(HOST_DATA_BUS_OUT, exp);
    HOST_READ_STROBE_N = 1'b1;
    PRINTER_PORT_SELECT_N = 1'b1;
    @(negedge CLOCK);
  endtask
  task automatic t_status;
    chk({7'h00, PRINTER_IRQ}, 8'h00);
    rd(3'h2, 8'h04, 1'b1);
    rd(3'h1, 8'hC8, 1'b1);
    err_now = 1'b1;
    repeat (2) @(negedge CLOCK);
    chk({7'h00, PRINTER_IRQ}, 8'h01);
    RESET = 1'b1;
    @(negedge CLOCK);
    chk({7'h00, PRINTER_IRQ}, 8'h00);
    RESET = 1'b0;
    repeat (2) @(negedge CLOCK);
    chk({7'h00, PRINTER_IRQ}, 8'h01);
    err_now = 1'b0;
    paper_now = 1'b1;
    repeat (2) @(negedge CLOCK);
    rd(3'h1, 8'hEC, 1'b1);
    paper_now = 1'b0;
    repeat (2) @(negedge CLOCK);
    chk({7'h00, PRINTER_IRQ}, 8'h00);
  endtask
  task automatic t_control;
    wr(3'h2, 8'h0B);
    chk({4'h0, PRINTER_LATCH_STROBE_N_IN, PAPER_AUTOFEED_N_IN, PRINTER_INIT_N_IN,
      PRINTER_SELECT_OUT_N_IN}, 8'h00);
    rd(3'h2, 8'h0B, 1'b1);
    rd(3'h1, 8'hD8, 1'b1);
    wr(3'h2, 8'h24);
    rd(3'h0, 8'h3C, 1'b1);
    wr(3'h2, 8'h04);
    chk({4'h0, PRINTER_LATCH_STROBE_N_IN, PAPER_AUTOFEED_N_IN, PRINTER_INIT_N_IN,
      PRINTER_SELECT_OUT_N_IN}, 8'h0F);
  endtask
  task automatic t_enable;
    PRINTER_OUTPUT_ENABLE_N = 1'b1;
    PRINTER_PORT_SELECT_N = 1'b0;
    @(negedge CLOCK);
    chk({3'h0, PRINTER_DATA_LINES_OE, PRINTER_LATCH_STROBE_N_OE, PAPER_AUTOFEED_N_OE,
      PRINTER_INIT_N_OE, PRINTER_SELECT_OUT_N_OE}, 8'h00);
    PRINTER_OUTPUT_ENABLE_N = 1'b0;
    @(negedge CLOCK);
    chk({3'h0, PRINTER_DATA_LINES_OE, PRINTER_LATCH_STROBE_N_OE, PAPER_AUTOFEED_N_OE,
      PRINTER_INIT_N_OE, PRINTER_SELECT_OUT_N_OE}, 8'h1F);
    PRINTER_PORT_SELECT_N = 1'b1;
    @(negedge CLOCK);
    chk({7'h00, PRINTER_DATA_LINES_OE}, 8'h00);
  endtask
  task automatic t_decode;
    SERIAL_ONE_SELECT = 1'b1;
    wr(3'h2, 8'h0F);
    rd(3'h2, 8'h00, 1'b0);
    SERIAL_ONE_SELECT = 1'b0;
    SERIAL_TWO_SELECT = 1'b1;
    HOST_READ_STROBE_N = 1'b0;
    @(negedge CLOCK);
    chk({6'h00, HOST_DATA_BUS_OE, BUS_BUFFER_DRIVE_OUT}, 8'h01);
    HOST_READ_STROBE_N = 1'b1;
    SERIAL_TWO_SELECT = 1'b0;
    @(negedge CLOCK);
    rd(3'h2, 8'h04, 1'b1);
    rd(3'h3, 8'h00, 1'b1);
  endtask
  task automatic t_buffer;
    wr(3'h0, 8'hA1);
    wr(3'h0, 8'hA2);
    chk({7'h00, BUF_IN_READY}, 8'h00);
    chk(PRINTER_DATA_LINES_OUT, 8'hA1);
    wr(3'h0, 8'hA3);
    rd(3'h0, 8'hA1, 1'b1);
    busy_now = 1'b0;
    @(negedge CLOCK);
    busy_now = 1'b1;
    rd(3'h0, 8'hA2, 1'b1);
    busy_now = 1'b0;
    repeat (3) @(negedge CLOCK);
    chk({7'h00, BUF_IN_READY}, 8'h01);
    rd(3'h1, 8'h08, 1'b1);
  endtask
  initial begin
    #5000;
    err_count++;
    give_verdict();
  end
  initial begin
    CLOCK = 1'b0;
    RESET = 1'b1;
    CE = 1'b1;
    {SERIAL_ONE_SELECT, SERIAL_TWO_SELECT, PRINTER_OUTPUT_ENABLE_N} = 3'h0;
    {PRINTER_PORT_SELECT_N, HOST_READ_STROBE_N, HOST_WRITE_STROBE_N} = 3'h7;
    HOST_ADDR = 3'h0;
    HOST_DATA_BUS_IN = 8'h00;
    {err_now, paper_now, busy_now} = 3'h1;
    repeat (10) @(negedge CLOCK);
    RESET = 1'b0;
    t_status();
    t_control();
    t_enable();
    t_decode();
    t_buffer();
    give_verdict();
  end
endmodule
